// ==== bef_event_flags.sv ====
// Purpose: Event flag register for data buffers 4 to 7 with enables and summary interrupts.
// Assumes: Event inputs are single-cycle pulses or levels from logic on the same clock.
// Notes:   Flags clear by writing one; unmapped reads return zero.
`timescale 1ns/1ps

module bef_event_flags (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  input  wire bef_pkg::bef_event_t buf_ev [4],
  output logic                     system_summary_buffer_irq3,
  output logic                     system_summary_buffer_irq2,
  output logic                     irq
);

  bef_pkg::bef_req_t req;
  logic [31:0]       buffer_event_flags_upper;
  logic [31:0]       buffer_event_enables_upper;
  logic [31:0]       flag_clear;
  logic [31:0]       valid_mask;
  logic [31:0]       next_rdata;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] word, input int unsigned idx);
    byte_of = word[idx*bef_pkg::BYTE_W +: bef_pkg::BYTE_W];
  endfunction

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  assign valid_mask = {bef_pkg::NUM_BUF{bef_pkg::BYTE_VALID_MASK}};

  // Write-one-to-clear on the flag register; reserved bits cannot be touched.
  assign flag_clear = (req.wr && hit(req.addr, bef_pkg::FLAGS_OFF)) ?
                      (req.wdata & valid_mask) : bef_pkg::REG_RESET;

  // Buffer 4 + n owns byte n, so buffer 7 sits in the top byte.
  for (genvar n = 0; n < bef_pkg::NUM_BUF; n++) begin : g_buf
    bef_flag_byte u_byte (
      .clk   (clk),
      .rst_n (rst_n),
      .ev    (buf_ev[n]),
      .clr   (flag_clear[n*bef_pkg::BYTE_W +: bef_pkg::BYTE_W]),
      .flags (buffer_event_flags_upper[n*bef_pkg::BYTE_W +: bef_pkg::BYTE_W])
    );
  end

  // Enable register; reserved bits are dropped on write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buffer_event_enables_upper <= bef_pkg::REG_RESET;
    end else if (req.wr && hit(req.addr, bef_pkg::ENABLE_OFF)) begin
      buffer_event_enables_upper <= req.wdata & valid_mask;
    end
  end

  bef_irq_gate u_gate_upper (
    .clk     (clk),
    .rst_n   (rst_n),
    .flags   (buffer_event_flags_upper[31:16]),
    .enables (buffer_event_enables_upper[31:16]),
    .summary (system_summary_buffer_irq3)
  );

  bef_irq_gate u_gate_lower (
    .clk     (clk),
    .rst_n   (rst_n),
    .flags   (buffer_event_flags_upper[15:0]),
    .enables (buffer_event_enables_upper[15:0]),
    .summary (system_summary_buffer_irq2)
  );

  assign irq = system_summary_buffer_irq3 | system_summary_buffer_irq2;

  // Named view of the flag register. The read word is rebuilt field by field so that a
  // misplaced flag or a live reserved slot shows up here, not only on the bus.
  logic [7:0]  flag_b7;
  logic [7:0]  flag_b6;
  logic [7:0]  flag_b5;
  logic [7:0]  flag_b4;
  logic        b7_cell_committed;
  logic        b7_release_due;
  logic        b7_expired_flush;
  logic        b7_upper_mark_rise;
  logic        b7_lower_mark_rise;
  logic        b7_no_space;
  logic        b7_no_data;
  logic        b6_cell_committed;
  logic        b6_release_due;
  logic        b6_expired_flush;
  logic        b6_upper_mark_rise;
  logic        b6_lower_mark_rise;
  logic        b6_no_space;
  logic        b6_no_data;
  logic        b5_cell_committed;
  logic        b5_release_due;
  logic        b5_expired_flush;
  logic        b5_upper_mark_rise;
  logic        b5_lower_mark_rise;
  logic        b5_no_space;
  logic        b5_no_data;
  logic        b4_cell_committed;
  logic        b4_release_due;
  logic        b4_expired_flush;
  logic        b4_upper_mark_rise;
  logic        b4_lower_mark_rise;
  logic        b4_no_space;
  logic        b4_no_data;
  logic [31:0] flag_word;

  assign flag_b7 = byte_of(buffer_event_flags_upper, bef_pkg::B7_BYTE);
  assign flag_b6 = byte_of(buffer_event_flags_upper, bef_pkg::B6_BYTE);
  assign flag_b5 = byte_of(buffer_event_flags_upper, bef_pkg::B5_BYTE);
  assign flag_b4 = byte_of(buffer_event_flags_upper, bef_pkg::B4_BYTE);

  assign b7_cell_committed  = flag_b7[bef_pkg::CELL_BIT];
  assign b7_release_due     = flag_b7[bef_pkg::RELEASE_BIT];
  assign b7_expired_flush   = flag_b7[bef_pkg::EXPIRED_BIT];
  assign b7_upper_mark_rise = flag_b7[bef_pkg::UPPER_BIT];
  assign b7_lower_mark_rise = flag_b7[bef_pkg::LOWER_BIT];
  assign b7_no_space        = flag_b7[bef_pkg::NO_SPACE_BIT];
  assign b7_no_data         = flag_b7[bef_pkg::NO_DATA_BIT];
  assign b6_cell_committed  = flag_b6[bef_pkg::CELL_BIT];
  assign b6_release_due     = flag_b6[bef_pkg::RELEASE_BIT];
  assign b6_expired_flush   = flag_b6[bef_pkg::EXPIRED_BIT];
  assign b6_upper_mark_rise = flag_b6[bef_pkg::UPPER_BIT];
  assign b6_lower_mark_rise = flag_b6[bef_pkg::LOWER_BIT];
  assign b6_no_space        = flag_b6[bef_pkg::NO_SPACE_BIT];
  assign b6_no_data         = flag_b6[bef_pkg::NO_DATA_BIT];
  assign b5_cell_committed  = flag_b5[bef_pkg::CELL_BIT];
  assign b5_release_due     = flag_b5[bef_pkg::RELEASE_BIT];
  assign b5_expired_flush   = flag_b5[bef_pkg::EXPIRED_BIT];
  assign b5_upper_mark_rise = flag_b5[bef_pkg::UPPER_BIT];
  assign b5_lower_mark_rise = flag_b5[bef_pkg::LOWER_BIT];
  assign b5_no_space        = flag_b5[bef_pkg::NO_SPACE_BIT];
  assign b5_no_data         = flag_b5[bef_pkg::NO_DATA_BIT];
  assign b4_cell_committed  = flag_b4[bef_pkg::CELL_BIT];
  assign b4_release_due     = flag_b4[bef_pkg::RELEASE_BIT];
  assign b4_expired_flush   = flag_b4[bef_pkg::EXPIRED_BIT];
  assign b4_upper_mark_rise = flag_b4[bef_pkg::UPPER_BIT];
  assign b4_lower_mark_rise = flag_b4[bef_pkg::LOWER_BIT];
  assign b4_no_space        = flag_b4[bef_pkg::NO_SPACE_BIT];
  assign b4_no_data         = flag_b4[bef_pkg::NO_DATA_BIT];

  assign flag_word = {
    b7_cell_committed,
    b7_release_due,
    b7_expired_flush,
    b7_upper_mark_rise,
    b7_lower_mark_rise,
    flag_b7[bef_pkg::SPARE_BIT],
    b7_no_space,
    b7_no_data,
    b6_cell_committed,
    b6_release_due,
    b6_expired_flush,
    b6_upper_mark_rise,
    b6_lower_mark_rise,
    flag_b6[bef_pkg::SPARE_BIT],
    b6_no_space,
    b6_no_data,
    b5_cell_committed,
    b5_release_due,
    b5_expired_flush,
    b5_upper_mark_rise,
    b5_lower_mark_rise,
    flag_b5[bef_pkg::SPARE_BIT],
    b5_no_space,
    b5_no_data,
    b4_cell_committed,
    b4_release_due,
    b4_expired_flush,
    b4_upper_mark_rise,
    b4_lower_mark_rise,
    flag_b4[bef_pkg::SPARE_BIT],
    b4_no_space,
    b4_no_data
  };

  // The enable register gets the same view, so both words visibly share one layout.
  logic [7:0]  enable_b7;
  logic [7:0]  enable_b6;
  logic [7:0]  enable_b5;
  logic [7:0]  enable_b4;
  logic        en_b7_cell_committed;
  logic        en_b7_release_due;
  logic        en_b7_expired_flush;
  logic        en_b7_upper_mark_rise;
  logic        en_b7_lower_mark_rise;
  logic        en_b7_no_space;
  logic        en_b7_no_data;
  logic        en_b6_cell_committed;
  logic        en_b6_release_due;
  logic        en_b6_expired_flush;
  logic        en_b6_upper_mark_rise;
  logic        en_b6_lower_mark_rise;
  logic        en_b6_no_space;
  logic        en_b6_no_data;
  logic        en_b5_cell_committed;
  logic        en_b5_release_due;
  logic        en_b5_expired_flush;
  logic        en_b5_upper_mark_rise;
  logic        en_b5_lower_mark_rise;
  logic        en_b5_no_space;
  logic        en_b5_no_data;
  logic        en_b4_cell_committed;
  logic        en_b4_release_due;
  logic        en_b4_expired_flush;
  logic        en_b4_upper_mark_rise;
  logic        en_b4_lower_mark_rise;
  logic        en_b4_no_space;
  logic        en_b4_no_data;
  logic [31:0] enable_word;

  assign enable_b7 = byte_of(buffer_event_enables_upper, bef_pkg::B7_BYTE);
  assign enable_b6 = byte_of(buffer_event_enables_upper, bef_pkg::B6_BYTE);
  assign enable_b5 = byte_of(buffer_event_enables_upper, bef_pkg::B5_BYTE);
  assign enable_b4 = byte_of(buffer_event_enables_upper, bef_pkg::B4_BYTE);

  assign en_b7_cell_committed  = enable_b7[bef_pkg::CELL_BIT];
  assign en_b7_release_due     = enable_b7[bef_pkg::RELEASE_BIT];
  assign en_b7_expired_flush   = enable_b7[bef_pkg::EXPIRED_BIT];
  assign en_b7_upper_mark_rise = enable_b7[bef_pkg::UPPER_BIT];
  assign en_b7_lower_mark_rise = enable_b7[bef_pkg::LOWER_BIT];
  assign en_b7_no_space        = enable_b7[bef_pkg::NO_SPACE_BIT];
  assign en_b7_no_data         = enable_b7[bef_pkg::NO_DATA_BIT];
  assign en_b6_cell_committed  = enable_b6[bef_pkg::CELL_BIT];
  assign en_b6_release_due     = enable_b6[bef_pkg::RELEASE_BIT];
  assign en_b6_expired_flush   = enable_b6[bef_pkg::EXPIRED_BIT];
  assign en_b6_upper_mark_rise = enable_b6[bef_pkg::UPPER_BIT];
  assign en_b6_lower_mark_rise = enable_b6[bef_pkg::LOWER_BIT];
  assign en_b6_no_space        = enable_b6[bef_pkg::NO_SPACE_BIT];
  assign en_b6_no_data         = enable_b6[bef_pkg::NO_DATA_BIT];
  assign en_b5_cell_committed  = enable_b5[bef_pkg::CELL_BIT];
  assign en_b5_release_due     = enable_b5[bef_pkg::RELEASE_BIT];
  assign en_b5_expired_flush   = enable_b5[bef_pkg::EXPIRED_BIT];
  assign en_b5_upper_mark_rise = enable_b5[bef_pkg::UPPER_BIT];
  assign en_b5_lower_mark_rise = enable_b5[bef_pkg::LOWER_BIT];
  assign en_b5_no_space        = enable_b5[bef_pkg::NO_SPACE_BIT];
  assign en_b5_no_data         = enable_b5[bef_pkg::NO_DATA_BIT];
  assign en_b4_cell_committed  = enable_b4[bef_pkg::CELL_BIT];
  assign en_b4_release_due     = enable_b4[bef_pkg::RELEASE_BIT];
  assign en_b4_expired_flush   = enable_b4[bef_pkg::EXPIRED_BIT];
  assign en_b4_upper_mark_rise = enable_b4[bef_pkg::UPPER_BIT];
  assign en_b4_lower_mark_rise = enable_b4[bef_pkg::LOWER_BIT];
  assign en_b4_no_space        = enable_b4[bef_pkg::NO_SPACE_BIT];
  assign en_b4_no_data         = enable_b4[bef_pkg::NO_DATA_BIT];

  assign enable_word = {
    en_b7_cell_committed,  en_b7_release_due,
    en_b7_expired_flush,   en_b7_upper_mark_rise,
    en_b7_lower_mark_rise, enable_b7[bef_pkg::SPARE_BIT],
    en_b7_no_space,        en_b7_no_data,
    en_b6_cell_committed,  en_b6_release_due,
    en_b6_expired_flush,   en_b6_upper_mark_rise,
    en_b6_lower_mark_rise, enable_b6[bef_pkg::SPARE_BIT],
    en_b6_no_space,        en_b6_no_data,
    en_b5_cell_committed,  en_b5_release_due,
    en_b5_expired_flush,   en_b5_upper_mark_rise,
    en_b5_lower_mark_rise, enable_b5[bef_pkg::SPARE_BIT],
    en_b5_no_space,        en_b5_no_data,
    en_b4_cell_committed,  en_b4_release_due,
    en_b4_expired_flush,   en_b4_upper_mark_rise,
    en_b4_lower_mark_rise, enable_b4[bef_pkg::SPARE_BIT],
    en_b4_no_space,        en_b4_no_data
  };

  always_comb begin
    next_rdata = bef_pkg::REG_RESET;
    if (req.rd) begin
      case (req.addr)
        bef_pkg::FLAGS_OFF: begin
          next_rdata = flag_word;
        end
        bef_pkg::ENABLE_OFF: begin
          next_rdata = enable_word;
        end
        bef_pkg::SUMMARY_OFF: begin
          next_rdata[bef_pkg::SUM_LOWER_PAIR_BIT] = system_summary_buffer_irq2;
          next_rdata[bef_pkg::SUM_UPPER_PAIR_BIT] = system_summary_buffer_irq3;
        end
        default: begin
          next_rdata = bef_pkg::REG_RESET;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= bef_pkg::REG_RESET;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== bef_pkg.sv ====
// Purpose: Shared constants and types for the upper data-buffer event flag block.
// Assumes: One system clock, synchronous active-low reset, 32-bit register port.
// Notes:   Byte n of the flag and enable registers belongs to buffer 4 + n.
package bef_pkg;

  localparam int unsigned NUM_BUF  = 4;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;

  // Register offsets.
  localparam logic [11:0] FLAGS_OFF   = 12'h154;
  localparam logic [11:0] ENABLE_OFF  = 12'h158;
  localparam logic [11:0] SUMMARY_OFF = 12'h15c;

  // Flag positions inside one buffer byte.
  localparam int unsigned CELL_BIT     = 7;
  localparam int unsigned RELEASE_BIT  = 6;
  localparam int unsigned EXPIRED_BIT  = 5;
  localparam int unsigned UPPER_BIT    = 4;
  localparam int unsigned LOWER_BIT    = 3;
  localparam int unsigned SPARE_BIT    = 2;
  localparam int unsigned NO_SPACE_BIT = 1;
  localparam int unsigned NO_DATA_BIT  = 0;

  // Byte index of each buffer inside a 32-bit register.
  localparam int unsigned B7_BYTE = 3;
  localparam int unsigned B6_BYTE = 2;
  localparam int unsigned B5_BYTE = 1;
  localparam int unsigned B4_BYTE = 0;

  // Bits that exist in a buffer byte; the reserved bit is always zero.
  localparam logic [7:0] BYTE_VALID_MASK = 8'hfb;
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

  // Summary register fields.
  localparam int unsigned SUM_LOWER_PAIR_BIT = 0;
  localparam int unsigned SUM_UPPER_PAIR_BIT = 1;

  // Event and level inputs for one buffer.
  typedef struct packed {
    logic cell_committed;
    logic release_due;
    logic expired_flush;
    logic upper_mark_lvl;
    logic lower_mark_lvl;
    logic no_space_lvl;
    logic no_data_lvl;
  } bef_event_t;

  // Register port request.
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bef_req_t;

endpackage

// ==== bef_flag_byte.sv ====
// Purpose: Sticky event flags for one data buffer.
// Assumes: Event inputs come from logic on the same clock.
// Notes:   A hardware set in the same cycle as a clear keeps the flag set.
`timescale 1ns/1ps
module bef_flag_byte (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire bef_pkg::bef_event_t ev,
  input  wire logic [7:0]         clr,
  output logic      [7:0]         flags
);

  logic       upper_prev;
  logic       lower_prev;
  logic [7:0] set_vec;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upper_prev <= 1'b0;
      lower_prev <= 1'b0;
    end else begin
      upper_prev <= ev.upper_mark_lvl;
      lower_prev <= ev.lower_mark_lvl;
    end
  end

  always_comb begin
    set_vec = bef_pkg::BYTE_RESET;
    set_vec[bef_pkg::CELL_BIT]     = ev.cell_committed;
    set_vec[bef_pkg::RELEASE_BIT]  = ev.release_due;
    set_vec[bef_pkg::EXPIRED_BIT]  = ev.expired_flush;
    set_vec[bef_pkg::UPPER_BIT]    = ev.upper_mark_lvl & ~upper_prev;
    set_vec[bef_pkg::LOWER_BIT]    = ev.lower_mark_lvl & ~lower_prev;
    set_vec[bef_pkg::NO_SPACE_BIT] = ev.no_space_lvl;
    set_vec[bef_pkg::NO_DATA_BIT]  = ev.no_data_lvl;
  end

  // Set wins over clear so an event in the clearing cycle is never lost.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= bef_pkg::BYTE_RESET;
    end else begin
      flags <= (set_vec | (flags & ~clr)) & bef_pkg::BYTE_VALID_MASK;
    end
  end

endmodule

// ==== bef_irq_gate.sv ====
// Purpose: Gate a group of flags by their enables onto one summary bit.
// Assumes: Flags and enables share a layout.
// Notes:   The summary is registered, so it follows a flag by one cycle.
`timescale 1ns/1ps
module bef_irq_gate (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] flags,
  input  wire logic [15:0] enables,
  output logic             summary
);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      summary <= 1'b0;
    end else begin
      summary <= |(flags & enables);
    end
  end

endmodule

// ==== bef_event_flags_sva.sv ====
// Purpose: Port assertions for the upper buffer event flag block.
// Assumes: Read data stand only in the cycle after a read strobe.
// Notes:   Flags are read one cycle after their cause, so no clear can slip in.
`timescale 1ns/1ps
module bef_event_flags_sva (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [11:0]         reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  input wire bef_pkg::bef_event_t buf_ev [4],
  input wire logic                system_summary_buffer_irq3,
  input wire logic                system_summary_buffer_irq2,
  input wire logic                irq
);
  wire r154 = reg_rd && reg_addr == 12'h154;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cell; buf_ev[3].cell_committed ##1 r154 |=> reg_rdata[31]; endproperty
  a_cell: assert property (p_cell) else $error("cell flag");
  property p_rel; buf_ev[2].release_due ##1 r154 |=> reg_rdata[22]; endproperty
  a_rel: assert property (p_rel) else $error("release flag");
  property p_exp; buf_ev[1].expired_flush ##1 r154 |=> reg_rdata[13]; endproperty
  a_exp: assert property (p_exp) else $error("expired flag");
  property p_up; $rose(buf_ev[0].upper_mark_lvl) ##1 r154 |=> reg_rdata[4]; endproperty
  a_up: assert property (p_up) else $error("upper mark flag");
  property p_lo; $rose(buf_ev[3].lower_mark_lvl) ##1 r154 |=> reg_rdata[27]; endproperty
  a_lo: assert property (p_lo) else $error("lower mark flag");
  property p_full; buf_ev[2].no_space_lvl ##1 r154 |=> reg_rdata[17]; endproperty
  a_full: assert property (p_full) else $error("full flag");
  property p_empty; buf_ev[1].no_data_lvl ##1 r154 |=> reg_rdata[8]; endproperty
  a_empty: assert property (p_empty) else $error("empty flag");
  property p_reserved_zero; (reg_rdata & 32'h0404_0404) == 32'h0; endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
  property p_hold; r154 ##1 !reg_wr ##1 r154 |=> ($past(reg_rdata, 2) & ~reg_rdata) == 0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
endmodule
bind bef_event_flags bef_event_flags_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .buf_ev(buf_ev), .system_summary_buffer_irq3(system_summary_buffer_irq3),
  .system_summary_buffer_irq2(system_summary_buffer_irq2), .irq(irq));

// ==== bef_event_flags_tb_top.sv ====
// Purpose: Register level tests of the upper buffer event flag block.
// Assumes: Strobes and events change by non-blocking assignment at rising edges.
// Notes:   Every flag of every buffer is set, read and cleared in turn.
`timescale 1ns/1ps
module bef_event_flags_tb_top;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [11:0]         reg_addr = 12'h000;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [31:0]         reg_rdata;
  logic                irq3;
  logic                irq2;
  logic                irq;
  bef_pkg::bef_event_t buf_ev [4] = '{4{7'h00}};
  int                  failures = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  always #2 clk = ~clk;
  bef_event_flags dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buf_ev(buf_ev),
    .system_summary_buffer_irq3(irq3), .system_summary_buffer_irq2(irq2), .irq(irq));
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("read data", exp, reg_rdata);
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    int fb;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h154, 32'h0);
    rd(12'h158, 32'h0);
    rd(12'h160, 32'h0);
    wr(12'h158, 32'hffff_ffff);
    rd(12'h158, 32'hfbfb_fbfb);
    for (int n = 0; n < 4; n++) begin
      for (int k = 0; k < 7; k++) begin
        fb = n * 8 + (k > 1 ? k + 1 : k);
        buf_ev[n] <= 7'h01 << k;
        @(posedge clk);
        buf_ev[n] <= 7'h00;
        rd(12'h154, 32'h1 << fb);
        chk("summary", n > 1 ? 32'h5 : 32'h3, {29'h0, irq3, irq2, irq});
        wr(12'h154, 32'h1 << fb);
        rd(12'h154, 32'h0);
      end
    end
    wr(12'h158, 32'h0);
    buf_ev[3] <= 7'h40;
    @(posedge clk);
    buf_ev[3] <= 7'h00;
    repeat (2) @(posedge clk);
    #1 chk("masked irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    wr(12'h158, 32'h8000_0000);
    repeat (2) @(posedge clk);
    #1 chk("enabled irq", 32'h3, {30'h0, irq3, irq});
    @(posedge clk);
    rd(12'h15c, 32'h2);
    wr(12'h154, 32'h8000_0000);
    repeat (2) @(posedge clk);
    #1 chk("cleared irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    buf_ev[0] <= 7'h40;
    wr(12'h154, 32'h0000_0080);
    buf_ev[0] <= 7'h00;
    repeat (2) rd(12'h154, 32'h0000_0080);
    print_verdict();
  end
endmodule
